// [logic/rrfs_core.sv]
// Decode and execute for rotate-right-no-carry and fill-ones
`timescale 1ns/1ps
`include "rrfs_cfg.svh"
module rrfs_core #(
	parameter int DATA_W = 8,   // Operand byte width
	parameter int ADDR_W = 12,  // Data memory address width
	parameter int BANK_W = 4,   // Bank number width
	parameter int INSN_W = 16   // Instruction word width
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        instr_valid,
	input  wire logic [15:0] instr_word,
	input  wire logic        ext_en,
	input  wire logic [3:0]  bank_select_reg,
	input  wire logic [11:0] index_base,
	input  wire logic [7:0]  general_purpose_byte,
	input  wire logic [7:0]  status_in,
	output logic             rd_req,
	output logic [11:0]      mem_addr,
	output logic             mem_we,
	output logic [7:0]       mem_wdata,
	output logic             wreg_we,
	output logic [7:0]       wreg_wdata,
	output logic             status_we,
	output logic [7:0]       status_out,
	output logic             ilo_mode,
	output logic             done
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Field positions and the bank split are fixed by the encoding,
	// so only the documented widths can be served
	generate
		if (DATA_W != 8) begin : g_bad_data_w
			$error("rrfs_core: DATA_W must be 8");
		end
		if (ADDR_W != 12) begin : g_bad_addr_w
			$error("rrfs_core: ADDR_W must be 12");
		end
		if (BANK_W != 4) begin : g_bad_bank_w
			$error("rrfs_core: BANK_W must be 4");
		end
		if (INSN_W != 16) begin : g_bad_insn_w
			$error("rrfs_core: INSN_W must be 16");
		end
	endgenerate

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic [11:0]        eff_addr;
	logic               ilo_used;
	rrfs_pkg::rrfs_op_t op;
	logic [7:0]         rot;
	logic               dest_bit;
	logic               bank_bit;
	logic [7:0]         file_addr;
	logic               rot_hit;
	logic               fill_hit;
	logic               rot_neg;
	logic               rot_zero;

	// Instruction fields; bank bit and file address serve both opcodes, the d bit only rotate
	assign dest_bit  = instr_word[`RRFS_D_BIT];
	assign bank_bit  = instr_word[`RRFS_A_BIT];
	assign file_addr = instr_word[7:0];

	// Opcode compares kept apart, each one narrow equality
	assign rot_hit  = (instr_word[15:10] == `RRFS_ROT_OPC);
	assign fill_hit = (instr_word[15:9] == `RRFS_FILL_OPC);

	// Effective address, also flags the indexed offset case
	rrfs_addr u_addr (
		.bank_bit        (bank_bit),
		.ext_en          (ext_en),
		.file_addr       (file_addr),
		.bank_select_reg (bank_select_reg),
		.index_base      (index_base),
		.eff_addr        (eff_addr),
		.ilo_used        (ilo_used)
	);

	// Opcode match, anything else is left to other decoders
	// Encodings are disjoint, so the priority order is arbitrary
	always_comb begin
		op = rrfs_pkg::RRFS_OP_NONE;
		if (instr_valid && rot_hit)
			op = rrfs_pkg::RRFS_OP_ROT;
		else if (instr_valid && fill_hit)
			op = rrfs_pkg::RRFS_OP_FILL;
	end

	// ----------------------------------------
	// Rotate datapath
	// ----------------------------------------
	// Bit i takes bit i+1, the top bit wraps from bit 0
	// Pure wiring: no carry input, no extra logic depth
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_rot
			if (gi == 7) begin : g_wrap
				assign rot[gi] = general_purpose_byte[0];
			end else begin : g_shift
				assign rot[gi] = general_purpose_byte[gi + 1];
			end
		end
	endgenerate

	// Flags come from the result, not the operand
	assign rot_neg  = rot[7];
	assign rot_zero = (rot == 8'h00);

	// ----------------------------------------
	// Execute: all outputs registered, one cycle per instruction
	// ----------------------------------------
	logic        next_rd_req;
	logic [11:0] next_mem_addr;
	logic        next_mem_we;
	logic [7:0]  next_mem_wdata;
	logic        next_wreg_we;
	logic [7:0]  next_wreg_wdata;
	logic        next_status_we;
	logic [7:0]  next_status_out;
	logic        next_ilo_mode;
	logic        next_done;

	always_comb begin
		next_rd_req     = 1'b0;
		next_mem_addr   = mem_addr;
		next_mem_we     = 1'b0;
		next_mem_wdata  = mem_wdata;
		next_wreg_we    = 1'b0;
		next_wreg_wdata = wreg_wdata;
		next_status_we  = 1'b0;
		next_status_out = status_out;
		next_ilo_mode   = ilo_mode;
		next_done       = 1'b0;
		case (op)
			rrfs_pkg::RRFS_OP_ROT: begin
				next_rd_req   = 1'b1;
				next_mem_addr = eff_addr;
				next_ilo_mode = ilo_used;
				next_done     = 1'b1;
				if (dest_bit) begin
					next_mem_we    = 1'b1;
					next_mem_wdata = rot;
				end else begin
					next_wreg_we    = 1'b1;
					next_wreg_wdata = rot;
				end
				// Only N and Z move; carry stays as it was
				next_status_we  = 1'b1;
				next_status_out = status_in;
				next_status_out[`RRFS_FLAG_N] = rot_neg;
				next_status_out[`RRFS_FLAG_Z] = rot_zero;
			end
			rrfs_pkg::RRFS_OP_FILL: begin
				next_mem_addr  = eff_addr;
				next_ilo_mode  = ilo_used;
				next_mem_we    = 1'b1;
				next_mem_wdata = `RRFS_FILL_VALUE;
				next_done      = 1'b1;
			end
			default: begin
				next_done = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Integration hazards
	// ----------------------------------------
	// Operand byte must be valid in the take cycle
	// Memory write lands one cycle after the take edge;
	// a back to back read of the same byte needs forwarding
	// outside this block
	// Status merge uses status_in of the take cycle, so a flag
	// write by the previous instruction must already show there
	// Address and data hold between instructions to save toggles
	// ilo_mode reports the last addressing mode, for trace only

	// Register stage, frozen while ce is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_req     <= 1'b0;
			mem_addr   <= 12'h000;
			mem_we     <= 1'b0;
			mem_wdata  <= 8'h00;
			wreg_we    <= 1'b0;
			wreg_wdata <= 8'h00;
			status_we  <= 1'b0;
			status_out <= 8'h00;
			ilo_mode   <= 1'b0;
			done       <= 1'b0;
		end else if (ce) begin
			rd_req     <= next_rd_req;
			mem_addr   <= next_mem_addr;
			mem_we     <= next_mem_we;
			mem_wdata  <= next_mem_wdata;
			wreg_we    <= next_wreg_we;
			wreg_wdata <= next_wreg_wdata;
			status_we  <= next_status_we;
			status_out <= next_status_out;
			ilo_mode   <= next_ilo_mode;
			done       <= next_done;
		end
	end
endmodule

// [pkg/rrfs_cfg.svh]
// Constants for the rotate-right and fill-ones decode block
// How it works
// - Rotate-right-no-carry opcode moves each bit of the byte down one place and old bit 0 into bit 7, carry untouched.
// - Rotate destination bit zero sends the result to the working register, one writes it back to the byte.
// - Bank bit zero addresses the access bank ignoring the bank select register, one takes the bank from it.
// - Bank bit zero with the extended set enabled uses indexed literal offset addressing for file addresses up to 95.
// - Fill-ones opcode writes 0xff into the addressed byte, with the same bank bit selection.
`ifndef RRFS_CFG_SVH
`define RRFS_CFG_SVH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define RRFS_ROT_OPC      6'h10
`define RRFS_FILL_OPC     7'h34
`define RRFS_D_BIT        9
`define RRFS_A_BIT        8
`define RRFS_ILO_LIMIT    8'h5f
`define RRFS_ACC_SPLIT    8'h60
`define RRFS_ACC_HI_BANK  4'hf
`define RRFS_FILL_VALUE   8'hff
`define RRFS_FLAG_N       4
`define RRFS_FLAG_Z       2
`endif

// [pkg/rrfs_pkg.sv]
// Types for the rotate-right and fill-ones decode block
package rrfs_pkg;
	typedef enum logic [1:0] {
		RRFS_OP_NONE = 2'b00,
		RRFS_OP_ROT  = 2'b01,
		RRFS_OP_FILL = 2'b10
	} rrfs_op_t;
endpackage

// [logic/rrfs_addr.sv]
// Effective data address generation for byte instructions
`timescale 1ns/1ps
`include "rrfs_cfg.svh"
module rrfs_addr (
	input  wire logic        bank_bit,
	input  wire logic        ext_en,
	input  wire logic [7:0]  file_addr,
	input  wire logic [3:0]  bank_select_reg,
	input  wire logic [11:0] index_base,
	output logic      [11:0] eff_addr,
	output logic             ilo_used
);
	// Access bank split low/high, or BANK_SELECT_REG bank, or indexed offset
	always_comb begin
		ilo_used = 1'b0;
		if (bank_bit) begin
			eff_addr = {bank_select_reg, file_addr};
		end else if (ext_en && (file_addr <= `RRFS_ILO_LIMIT)) begin
			ilo_used = 1'b1;
			eff_addr = index_base + {4'h0, file_addr};
		end else if (file_addr < `RRFS_ACC_SPLIT) begin
			eff_addr = {4'h0, file_addr};
		end else begin
			eff_addr = {`RRFS_ACC_HI_BANK, file_addr};
		end
	end
endmodule

// [verif/rrfs_core_chk.sv]
// Checker for the rotate and fill decode block
`timescale 1ns/1ps
module rrfs_core_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        instr_valid,
	input wire logic        ext_en,
	input wire logic        mem_we,
	input wire logic        wreg_we,
	input wire logic        status_we,
	input wire logic        ilo_mode,
	input wire logic        done,
	input wire logic [15:0] instr_word,
	input wire logic [3:0]  bank_select_reg,
	input wire logic [11:0] index_base,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0]  general_purpose_byte,
	input wire logic [7:0]  mem_wdata,
	input wire logic [7:0]  wreg_wdata,
	input wire logic [7:0]  status_out
);
	wire rot = ce && instr_valid && instr_word[15:10] == 6'h10;
	wire fil = ce && instr_valid && instr_word[15:9] == 7'h34;
	wire [7:0] f = instr_word[7:0];
	wire [7:0] b = general_purpose_byte;
	wire [11:0] ia = index_base + {4'h0, f};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	rot_data_a: assert property (rot |=> (mem_we ? mem_wdata : wreg_wdata) == {$past(b[0]), $past(b[7:1])})
		else $error("bad rotate");
	dest_sel_a: assert property (rot |=> mem_we == $past(instr_word[9]) && wreg_we == !mem_we)
		else $error("bad destination");
	bank_addr_a: assert property ((rot || fil) && instr_word[8] |=> mem_addr == {$past(bank_select_reg), $past(f)})
		else $error("bad bank");
	index_addr_a: assert property ((rot || fil) && !instr_word[8] && ext_en && f <= 8'h5f
		|=> ilo_mode && mem_addr == $past(ia)) else $error("bad indexed address");
	access_bank_a: assert property ((rot || fil) && !instr_word[8] && !(ext_en && f <= 8'h5f)
		|=> !ilo_mode && mem_addr == {(($past(f) > 8'h5f) ? 4'hf : 4'h0), $past(f)}) else $error("bad access bank");
	fill_ones_a: assert property (fil |=> mem_we && mem_wdata == 8'hff && !wreg_we) else $error("bad fill");
	status_flags_a: assert property ((rot || fil) |=> done && status_we == $past(rot) && (!status_we ||
		status_out[4] == $past(b[0]) && status_out[2] == ($past(b) == 8'h00))) else $error("bad status");
	cover property (rot && instr_word[9]);
	cover property (rot && !instr_word[9]);
	cover property (fil && ext_en && !instr_word[8]);
	cover property (rot && ext_en && !instr_word[8]);
endmodule
bind rrfs_core rrfs_core_chk u_chk (.*);

// [verif/rrfs_mem_model.sv]
// Data memory model serving the addressed byte
`timescale 1ns/1ps
module rrfs_mem_model (
	input  wire logic        clk,
	input  wire logic        ext_en,
	input  wire logic        mem_we,
	input  wire logic [15:0] instr_word,
	input  wire logic [3:0]  bank_select_reg,
	input  wire logic [11:0] index_base,
	input  wire logic [11:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  general_purpose_byte
);
	logic [7:0] mem [4096];
	wire [7:0] f = instr_word[7:0];
	// Same-cycle byte at the decoded address
	assign general_purpose_byte = mem[instr_word[8] ? {bank_select_reg, f} : ext_en && f < 8'h60 ?
		index_base + {4'h0, f} : {f > 8'h5f ? 4'hf : 4'h0, f}];
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;
	always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
endmodule

// [verif/rotate_right_and_set_ops_tb.sv]
// Testbench for the rotate and fill decode block
`timescale 1ns/1ps
module rotate_right_and_set_ops_tb;
	logic clk = 0, rst = 1, ce = 1, instr_valid = 0, ext_en = 1;
	logic rd_req, mem_we, wreg_we, status_we, ilo_mode, done;
	logic [15:0] instr_word = 16'h0;
	logic [3:0] bank_select_reg = 4'h3;
	logic [11:0] index_base = 12'h200, mem_addr;
	logic [7:0] status_in = 8'h0, general_purpose_byte, mem_wdata, wreg_wdata, status_out;
	int miscompares = 0, samples_checked = 0;
	rrfs_core dut (.*);
	rrfs_mem_model m (.*);
	initial forever #10 clk = ~clk;
	task chk(input logic [15:0] s, e);
		samples_checked++;
		if (s !== e) begin
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
			miscompares++;
		end
	endtask
	task op(input logic [15:0] w);
		@(posedge clk);
		#1 instr_word = w;
		instr_valid = 1;
		@(posedge clk);
		#1 instr_valid = 0;
	endtask
	task test_rot;
		op(16'h4321);
		chk(mem_wdata, 8'hbd);
		chk(mem_addr, 12'h321);
		op(16'h4121);
		chk({mem_we, wreg_we, wreg_wdata}, 10'h1de);
		status_in = 8'hff;
		op(16'h435a);
		chk({rd_req, done, status_out}, 10'h3ef);
		op(16'h4010);
		chk({ilo_mode, mem_addr}, 13'h1210);
		chk({mem_we, wreg_we}, 2'h1);
		chk(wreg_wdata, 8'h25);
		chk(status_out, 8'heb);
		op(16'h4421);
		chk({done, mem_we}, 2'h0);
		$display("rotate done");
	endtask
	task test_fill;
		logic [15:0] fw [4] = '{16'h685f, 16'h6860, 16'h6850, 16'h6910};
		logic [11:0] ea [4] = '{12'h25f, 12'hf60, 12'h050, 12'h310};
		logic [3:0] ex = 4'b1011;
		logic [3:0] il = 4'b0001;
		for (int i = 0; i < 4; i++) begin
			ext_en = ex[i];
			op(fw[i]);
			chk({ilo_mode, mem_addr}, {il[i], ea[i]});
			chk({status_we, wreg_we, mem_wdata}, 10'h0ff);
		end
		$display("fill done");
	endtask
	task test_hold;
		@(posedge clk);
		#1 ce = 0;
		op(16'h6930);
		chk({done, mem_we, mem_addr}, 14'h0310);
		ce = 1;
		op(16'h6930);
		chk({done, mem_addr}, 13'h1330);
		rst = 1;
		#1 chk({done, mem_we, mem_addr}, 14'h0000);
		@(posedge clk);
		#1 rst = 0;
		op(16'h4321);
		chk(mem_wdata, 8'hde);
		$display("hold and reset done");
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 0;
		test_rot;
		test_fill;
		test_hold;
		test_done;
	end
	initial begin
		#20000;
		miscompares++;
		test_done;
	end
endmodule
